// file: src/uart_rx_sampling_wakeup.sv
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module uart_rx_sampling_wakeup (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rx_sample_tick,
    input wire logic serial_rx_pin,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic rx_full_flag,
    output logic noise_flag,
    output logic framing_error_flag,
    output logic rx_standby_request
);
    uart_rx_pkg::rx_state_t state;
    logic enable;
    logic len9;
    logic wake_addr;
    logic idle_after_stop;
    logic idle_flag;
    logic idle_seen;
    logic [8:0] data_buf;
    logic [8:0] shifter;
    logic [3:0] bit_idx;
    logic [4:0] rt;
    logic [2:0] history;
    logic [4:0] since_edge;
    logic prev_bit;
    logic noise_acc;
    logic ack;
    logic [31:0] ctl_word;
    logic [31:0] st_word;

    rx_link_if lnk ();

    rx_vote u_vote (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .lnk(lnk)
    );

    rx_idle u_idle (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .lnk(lnk)
    );

    // bus handshake: every access waits exactly one cycle
    wire logic req = read | write;
    wire logic wr_ok = write & ack;
    wire logic rd_ok = read & ack;
    wire logic hit_ctl = (address == `REG_CONTROL);
    wire logic hit_data = (address == `REG_DATA);
    wire logic ctl_wr = wr_ok & hit_ctl;
    wire logic rd_clear = rd_ok & hit_data;
    assign waitrequest = req & ~ack;

    // sample tick gated by the port enable
    wire logic tick = rx_sample_tick & enable; // RL21
    wire logic in_hunt = (state == uart_rx_pkg::st_hunt);
    wire logic in_start = (state == uart_rx_pkg::st_start);
    wire logic in_data = (state == uart_rx_pkg::st_data);
    wire logic in_stop = (state == uart_rx_pkg::st_stop);
    wire logic at_v1 = tick & (rt == `TICK_V1);
    wire logic at_v2 = tick & (rt == `TICK_V2);
    wire logic at_v3 = tick & (rt == `TICK_V3);
    wire logic at_d1 = tick & (rt == `TICK_D1);
    wire logic at_d2 = tick & (rt == `TICK_D2);
    wire logic at_d3 = tick & (rt == `TICK_D3);
    wire logic at_last = tick & (rt == `TICK_LAST);
    wire logic at_mid = at_d1 | at_d2 | at_d3;

    // three highs then a low opens a candidate start bit
    wire logic edge_start = tick & in_hunt & (history == 3'h7)
        & ~serial_rx_pin; // RL3
    wire logic falling = tick & history[0] & ~serial_rx_pin;
    wire logic [4:0] edge_off = falling ? 5'h00 : since_edge;
    wire logic start_fail = in_start & at_v3 & lnk.maj; // RL4
    wire logic resync = in_data & at_d3 & prev_bit & ~lnk.maj
        & (edge_off < 5'h0f); // RL2

    // character length sets the stop position and the msb
    wire logic [3:0] data_bits = len9 ? `DATA_BITS_LONG
        : `DATA_BITS_SHORT; // RL16
    wire logic last_bit = (bit_idx == data_bits); // RL16
    wire logic msb = len9 ? shifter[8] : shifter[7]; // RL16

    // end of stop bit and the fate of the character
    wire logic stop_done = in_stop & at_d3;
    wire logic wake_addr_ev = stop_done & rx_standby_request & wake_addr
        & msb; // RL11
    wire logic deliver = stop_done & (~rx_standby_request
        | wake_addr_ev); // RL10
    wire logic wake_idle_ev = rx_standby_request & ~wake_addr
        & lnk.idle_level; // RL13
    wire logic idle_rise = lnk.idle_level & ~idle_seen;

    // voter and idle counter feeds
    assign lnk.tick = tick;
    assign lnk.line = serial_rx_pin;
    assign lnk.len9 = len9;
    assign lnk.take = (in_start & (at_v1 | at_v2 | at_v3))
        | (~in_hunt & at_mid); // RL6
    assign lnk.hold = ~enable | (idle_after_stop ? ~in_hunt
        : in_start); // RL14

    // sequencer moves only on ticks
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !enable) begin
            state <= uart_rx_pkg::st_hunt; // RL21
        end else if (tick) begin
            unique case (state)
                uart_rx_pkg::st_hunt: begin
                    if (edge_start) begin
                        state <= uart_rx_pkg::st_start; // RL3
                    end
                end
                uart_rx_pkg::st_start: begin
                    if (start_fail) begin
                        state <= uart_rx_pkg::st_hunt; // RL5
                    end else if (at_last) begin
                        state <= uart_rx_pkg::st_data;
                    end
                end
                uart_rx_pkg::st_data: begin
                    if (at_last && last_bit) begin
                        state <= uart_rx_pkg::st_stop; // RL16
                    end
                end
                uart_rx_pkg::st_stop: begin
                    if (at_d3) begin
                        state <= uart_rx_pkg::st_hunt;
                    end
                end
            endcase
        end
    end

    // rt holds the number of the next tick to come, 1..16
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !enable) begin
            rt <= `TICK_FIRST; // RL21
        end else if (tick) begin
            if (in_hunt) begin
                rt <= edge_start ? `TICK_FIRST + 5'h01 : `TICK_FIRST; // RL3
            end else if (start_fail || stop_done) begin
                rt <= `TICK_FIRST; // RL5
            end else if (resync) begin
                rt <= edge_off + 5'h02; // RL2
            end else if (rt == `TICK_LAST) begin
                rt <= `TICK_FIRST; // RL1
            end else begin
                rt <= rt + 5'h01; // RL1
            end
        end
    end

    // recent raw samples, and ticks since the last raw falling edge
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !enable) begin
            history <= 3'h0;
            since_edge <= `SINCE_EDGE_RESET;
        end else if (tick) begin
            history <= {history[1:0], serial_rx_pin};
            if (falling) begin
                since_edge <= 5'h01; // RL2 edge tick is one tick back
            end else if (since_edge != `SINCE_EDGE_RESET) begin
                since_edge <= since_edge + 5'h01;
            end
        end
    end

    // data bits land at their own index, lsb first
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shifter <= 9'h000;
            bit_idx <= 4'h0;
            prev_bit <= 1'b0;
        end else if (edge_start) begin
            shifter <= 9'h000;
            bit_idx <= 4'h0;
            prev_bit <= 1'b0; // start bit counts as the prior low
        end else if (in_data && at_d3) begin
            shifter[bit_idx] <= lnk.maj; // RL6
            prev_bit <= lnk.maj;
            bit_idx <= bit_idx + 4'h1;
        end
    end

    // noise from every sampled bit of the character
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            noise_acc <= 1'b0;
        end else if (edge_start) begin
            noise_acc <= 1'b0; // RL20
        end else if (in_start && at_v3 && !lnk.maj && lnk.disagree) begin
            noise_acc <= 1'b1; // RL4
        end else if (in_start && at_d3 && lnk.any_high) begin
            noise_acc <= 1'b1; // RL7
        end else if (in_data && at_d3 && lnk.disagree) begin
            noise_acc <= 1'b1; // RL6
        end
    end

    // status flags: a data read clears, a new event wins the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_full_flag <= 1'b0;
            noise_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            data_buf <= 9'h000;
        end else begin
            if (rd_clear) begin
                rx_full_flag <= 1'b0;
                noise_flag <= 1'b0;
                framing_error_flag <= 1'b0;
            end
            if (deliver) begin
                data_buf <= shifter; // a break leaves all zeros
                rx_full_flag <= 1'b1; // RL11
                framing_error_flag <= ~lnk.maj; // RL8 RL9
                noise_flag <= noise_acc | lnk.disagree; // RL8 RL20
            end
        end
    end

    // idle flag only on a fresh idle and never while in standby
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            idle_flag <= 1'b0;
            idle_seen <= 1'b0;
        end else begin
            idle_seen <= lnk.idle_level;
            if (rd_clear) begin
                idle_flag <= 1'b0;
            end
            if (idle_rise && !rx_standby_request) begin
                idle_flag <= 1'b1; // RL13 RL19
            end
        end
    end

    // software write beats a hardware wake in the same cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_standby_request <= `CTL_RESET;
        end else if (ctl_wr) begin
            rx_standby_request <= writedata[`CTL_STANDBY]; // RL10
        end else if (wake_addr_ev || wake_idle_ev) begin
            rx_standby_request <= 1'b0; // RL11 RL13 RL15
        end
    end

    // configuration bits, all cleared by reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            enable <= `CTL_RESET;
            len9 <= `CTL_RESET;
            wake_addr <= `CTL_RESET; // RL17
            idle_after_stop <= `CTL_RESET; // RL18
        end else if (ctl_wr) begin
            enable <= writedata[`CTL_ENABLE];
            len9 <= writedata[`CTL_LEN9];
            wake_addr <= writedata[`CTL_WAKE_ADDR]; // RL17
            idle_after_stop <= writedata[`CTL_IDLE_AFTER_STOP]; // RL18
        end
    end

    // read views of control and status
    always_comb begin
        ctl_word = 32'h0;
        ctl_word[`CTL_ENABLE] = enable;
        ctl_word[`CTL_LEN9] = len9;
        ctl_word[`CTL_WAKE_ADDR] = wake_addr;
        ctl_word[`CTL_IDLE_AFTER_STOP] = idle_after_stop;
        ctl_word[`CTL_STANDBY] = rx_standby_request;
        st_word = 32'h0;
        st_word[`ST_FULL] = rx_full_flag;
        st_word[`ST_NOISE] = noise_flag;
        st_word[`ST_FRAMING] = framing_error_flag;
        st_word[`ST_IDLE] = idle_flag;
        st_word[`ST_STANDBY] = rx_standby_request;
        st_word[`ST_BUSY] = ~in_hunt;
    end

    // ack pulses for one cycle; read data loaded beside it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // unmapped offsets read as zero, writes to them are dropped
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            readdata <= 32'h0;
        end else if (read && !ack) begin
            case (address)
                `REG_CONTROL: readdata <= ctl_word;
                `REG_STATUS: readdata <= st_word;
                `REG_DATA: readdata <= {23'h0, data_buf};
                default: readdata <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_start_edge;
        in_hunt && edge_start;
    endsequence

    sequence s_one_then_zero;
        in_data && at_d3 && prev_bit && !lnk.maj && (edge_off < 5'h0f);
    endsequence

    sequence s_address_mark;
        stop_done && rx_standby_request && wake_addr && msb && !ctl_wr;
    endsequence

    sequence s_idle_wake;
        wake_idle_ev && !ctl_wr;
    endsequence

    a_rt_no_tick: assert property ( // RL21
        (!rx_sample_tick && enable) |=> (rt == $past(rt)))
        else $error("tick count moved without a tick");

    a_disabled_hunt: assert property ( // RL21
        !enable |=> (in_hunt && rt == `TICK_FIRST))
        else $error("disabled port left the search state");

    a_start_found: assert property ( // RL3
        s_start_edge |=> (in_start && rt == 5'h02))
        else $error("start edge not taken as tick one");

    a_start_reject: assert property ( // RL5
        (in_start && at_v3 && lnk.maj) |=> (in_hunt && rt == `TICK_FIRST))
        else $error("failed start check did not restart search");

    a_start_pass: assert property ( // RL4
        (in_start && at_v3 && !lnk.maj) |=> in_start
            ##0 (noise_acc == $past(lnk.disagree)))
        else $error("start check pass or noise wrong");

    a_resync_edge: assert property ( // RL2
        s_one_then_zero |=> (rt == $past(edge_off) + 5'h02))
        else $error("no realignment on data falling edge");

    a_data_vote: assert property ( // RL6
        (in_data && at_d3) |=> (shifter[$past(bit_idx)] == $past(lnk.maj)))
        else $error("data bit is not the majority");

    a_stop_frame: assert property ( // RL9
        deliver |=> (rx_full_flag && framing_error_flag == !$past(lnk.maj)))
        else $error("framing flag not raised with receive full");

    a_noise_report: assert property ( // RL20
        deliver |=> (noise_flag == ($past(noise_acc) | $past(lnk.disagree))))
        else $error("noise not reported with the character");

    a_standby_quiet: assert property ( // RL10
        (stop_done && rx_standby_request && !(wake_addr && msb)
            && !rx_full_flag)
            |=> !rx_full_flag)
        else $error("standby receiver reported a character");

    a_addr_wake: assert property ( // RL11
        s_address_mark |=> (!rx_standby_request && rx_full_flag))
        else $error("address mark did not wake the receiver");

    a_idle_wake: assert property ( // RL13
        s_idle_wake |=> (!rx_standby_request && !$rose(idle_flag)
            && !$rose(rx_full_flag)))
        else $error("idle wake wrong");

    a_idle_select: assert property ( // RL14
        (enable && idle_after_stop && !in_hunt) |-> lnk.hold)
        else $error("idle count ran during a frame");

    a_bus_answer: assert property (
        (req && !ack) |=> (!waitrequest ##1 (!req || waitrequest)))
        else $error("bus answer not after one wait cycle");
endmodule : uart_rx_sampling_wakeup

// file: src/uart_rx_map.svh
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH
// Function
// RL1: sample the receive pin on a tick at sixteen times baud, numbered 1..16
// RL2: realign tick count after start bit and on voted one-to-zero data change
// RL3: start search wants a low sample after three highs, then count to 16
// RL4: start bit checked at ticks 3,5,7; two highs fail, one high flags noise
// RL5: failed start check resets tick count and resumes the search
// RL6: data bit is majority of ticks 8,9,10; disagreement flags noise
// RL7: after a good start check, any high at ticks 8..10 flags noise only
// RL8: stop bit voted at ticks 8,9,10; low majority is a framing error
// RL9: framing error, breaks included, is raised together with receive full
// RL10: standby request holds the receiver quiet, no receive events reported
// RL11: address-mark wake: character with msb set clears standby, sets full
// RL12: software compares the address and may re-enter standby on mismatch
// RL13: idle-line wake: idle clears standby, sets neither idle nor full flag
// RL14: idle count start select picks where counting of high bits begins
// RL15: standby requested on an already idle line may wake at once
// RL16: length select picks 8 or 9 data bits, stop position and msb
// RL17: wake select: 1 address mark, 0 idle line; cleared by reset
// RL18: idle start select: 1 after stop bit, 0 after start bit; reset clears
// RL19: idle line seen after 10 or 11 high bit times, by character length
// RL20: noise gathered over the character, reported with receive full
// RL21: tick count moves only on baud ticks, held in search while disabled

// register byte offsets
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_DATA 4'h8
// control fields
`define CTL_ENABLE 0
`define CTL_LEN9 1
`define CTL_WAKE_ADDR 2
`define CTL_IDLE_AFTER_STOP 3
`define CTL_STANDBY 4
// status fields
`define ST_FULL 0
`define ST_NOISE 1
`define ST_FRAMING 2
`define ST_IDLE 3
`define ST_STANDBY 4
`define ST_BUSY 5
// reset values
`define CTL_RESET 1'b0
`define SINCE_EDGE_RESET 5'h1f
// tick numbers within one bit period
`define TICK_FIRST 5'h01
`define TICK_V1 5'h03
`define TICK_V2 5'h05
`define TICK_V3 5'h07
`define TICK_D1 5'h08
`define TICK_D2 5'h09
`define TICK_D3 5'h0a
`define TICK_LAST 5'h10
// character and idle counts
`define DATA_BITS_SHORT 4'h8
`define DATA_BITS_LONG 4'h9
`define IDLE_BITS_SHORT 8'h0a
`define IDLE_BITS_LONG 8'h0b
`define TICKS_PER_BIT 8'h10
`endif

// file: src/uart_rx_pkg.sv
package uart_rx_pkg;
    // receive sequencer, gray coded along search-start-data-stop
    typedef enum logic [1:0] {
        st_hunt = 2'b00,
        st_start = 2'b01,
        st_data = 2'b11,
        st_stop = 2'b10
    } rx_state_t;
endpackage : uart_rx_pkg

// file: src/rx_link_if.sv
`timescale 1ns/1ps
interface rx_link_if;
    logic tick;
    logic line;
    logic take;
    logic maj;
    logic disagree;
    logic any_high;
    logic hold;
    logic len9;
    logic idle_level;
    modport voter (input tick, line, take, output maj, disagree, any_high);
    modport idle (input tick, line, hold, len9, output idle_level);
    modport core (output tick, line, take, hold, len9,
        input maj, disagree, any_high, idle_level);
endinterface : rx_link_if

// file: src/rx_vote.sv
`timescale 1ns/1ps
module rx_vote (
    input wire logic sys_clk,
    input wire logic rst_b,
    rx_link_if.voter lnk
);
    logic [1:0] held;
    logic [2:0] trio;

    // two earlier samples kept; the third is the pin itself this tick
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            held <= 2'h0;
        end else if (lnk.tick && lnk.take) begin
            held <= {held[0], lnk.line};
        end
    end

    // vote is ready in the same cycle as the third sample
    assign trio = {held, lnk.line};
    assign lnk.maj = (trio[0] & trio[1]) | (trio[0] & trio[2])
        | (trio[1] & trio[2]);
    assign lnk.disagree = (|trio) & ~(&trio);
    assign lnk.any_high = |trio;
endmodule : rx_vote

// file: src/rx_idle.sv
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module rx_idle (
    input wire logic sys_clk,
    input wire logic rst_b,
    rx_link_if.idle lnk
);
    logic [7:0] run;
    logic [7:0] limit;

    // 10 or 11 bit times of sixteen ticks each
    assign limit = lnk.len9 ? `IDLE_BITS_LONG * `TICKS_PER_BIT
        : `IDLE_BITS_SHORT * `TICKS_PER_BIT; // RL19

    // saturating run of high ticks; any low sample restarts it
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            run <= 8'h00;
        end else if (lnk.hold) begin
            run <= 8'h00; // RL14
        end else if (lnk.tick) begin
            if (!lnk.line) begin
                run <= 8'h00;
            end else if (run < limit) begin
                run <= run + 8'h01; // RL19
            end
        end
    end

    // a level, so standby set on a quiet line sees it at once
    assign lnk.idle_level = (run >= limit); // RL15
endmodule : rx_idle

// file: verification/uart_tx_model.sv
`timescale 1ns/1ps
// remote transmitter: start, lsb first data, stop, 16 ticks per bit
module uart_tx_model (
    input wire logic sys_clk,
    input wire logic tick,
    input wire logic go,
    input wire logic len9,
    input wire logic stop_val,
    input wire logic [8:0] data,
    input wire logic [7:0] glitch,
    input wire logic [7:0] cut,
    output logic line = 1'b1,
    output logic busy = 1'b0
);
    logic [7:0] t = 8'h00;
    logic [7:0] total;
    // level of tick slot n; one slot may be inverted to fake noise
    function automatic logic level(input logic [7:0] n);
        logic [3:0] b;
        logic v;
        b = n[7:4];
        if (cut != 8'h00 || b == 4'h0) begin
            v = 1'b0;
        end else if (b <= (len9 ? 4'h9 : 4'h8)) begin
            v = data[b - 4'h1];
        end else begin
            v = stop_val;
        end
        return v ^ (glitch != 8'h00 && n == glitch);
    endfunction : level
    // a cut frame is a short low pulse only, a start that must fail
    assign total = (cut != 8'h00) ? cut : (len9 ? 8'hb0 : 8'ha0);
    // line is always driven; between frames it rests at mark level
    always @(posedge sys_clk) begin
        if (!busy) begin
            line <= go ? level(8'h00) : 1'b1;
            busy <= go;
            t <= 8'h00;
        end else if (tick) begin
            if (t == total - 8'h01) begin
                busy <= 1'b0;
                line <= 1'b1;
            end else begin
                t <= t + 8'h01;
                line <= level(t + 8'h01);
            end
        end
    end
endmodule : uart_tx_model

// file: verification/test_uart_rx_sampling_wakeup.sv
`timescale 1ns/1ps
`include "uart_rx_map.svh"
module test_uart_rx_sampling_wakeup;
    logic sys_clk;
    logic rst_b;
    logic rx_sample_tick = 1'b0;
    logic serial_rx_pin;
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic rx_full_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic rx_standby_request;
    logic go;
    logic len9;
    logic stop_val;
    logic [8:0] tx_data;
    logic [7:0] glitch;
    logic [7:0] cut;
    logic tx_busy;
    logic [1:0] tick_div = 2'h0;
    logic [31:0] rd;
    logic [7:0] gl [0:3] = '{8'h04, 8'h08, 8'h48, 8'h98};
    int miscompares = 0;
    int checks_done = 0;
    localparam logic [31:0] c_en = 32'h1 << `CTL_ENABLE;
    localparam logic [31:0] c_l9 = 32'h1 << `CTL_LEN9;
    localparam logic [31:0] c_wk = 32'h1 << `CTL_WAKE_ADDR;
    localparam logic [31:0] c_st = 32'h1 << `CTL_IDLE_AFTER_STOP;
    localparam logic [31:0] c_sb = 32'h1 << `CTL_STANDBY;

    uart_rx_sampling_wakeup dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
        .rx_sample_tick(rx_sample_tick), .serial_rx_pin(serial_rx_pin),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_full_flag(rx_full_flag),
        .noise_flag(noise_flag), .framing_error_flag(framing_error_flag),
        .rx_standby_request(rx_standby_request));
    uart_tx_model tx_u (.sys_clk(sys_clk), .tick(rx_sample_tick), .go(go),
        .len9(len9), .stop_val(stop_val), .data(tx_data), .glitch(glitch),
        .cut(cut), .line(serial_rx_pin), .busy(tx_busy));

    // 40 MHz clock; sample tick every fourth cycle keeps frames short
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        tick_div <= tick_div + 2'h1;
        rx_sample_tick <= (tick_div == 2'h3);
    end
    task automatic chk_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit
    task automatic chk_word(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge sys_clk iff rx_sample_tick);
        @(negedge sys_clk);
    endtask : wait_ticks
    // request held until waitrequest is seen low at a rising edge
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        read <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(negedge sys_clk);
    endtask : bus_rd
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(negedge sys_clk);
    endtask : bus_wr
    // mark time first, so the receiver sees three high samples
    task automatic send(input logic [8:0] d, input logic l, input logic s,
        input logic [7:0] g, input logic [7:0] c);
        wait_ticks(4);
        @(posedge sys_clk);
        tx_data <= d;
        len9 <= l;
        stop_val <= s;
        glitch <= g;
        cut <= c;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        do begin
            @(negedge sys_clk);
        end while (tx_busy === 1'b1);
        wait_ticks(4);
    endtask : send
    // flags of a delivered character, then the data read that clears them
    task automatic frame_check(input logic [8:0] e, input logic en,
        input logic ef);
        chk_bit("full", 1'b1, rx_full_flag);
        chk_bit("noise", en, noise_flag);
        chk_bit("framing", ef, framing_error_flag);
        bus_rd(`REG_DATA, rd);
        chk_word("data", {23'h0, e}, rd);
        chk_bit("full cleared", 1'b0, rx_full_flag);
    endtask : frame_check
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // watchdog far beyond the roughly 11500 cycles the tests need
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        test_done();
    end
    initial begin
        rst_b = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        {go, len9, stop_val, tx_data, glitch, cut} = 28'h0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        bus_rd(`REG_CONTROL, rd);
        chk_word("control reset", 32'h0, rd);
        send(9'h055, 1'b0, 1'b1, 8'h00, 8'h00);
        chk_bit("full disabled", 1'b0, rx_full_flag);
        bus_wr(4'hc, 32'hff);
        bus_rd(4'hc, rd);
        chk_word("unmapped", 32'h0, rd);
        $display("test reset done");
        bus_wr(`REG_CONTROL, c_en);
        send(9'h0a5, 1'b0, 1'b1, 8'h00, 8'h00);
        frame_check(9'h0a5, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            send(9'h05a, 1'b0, 1'b1, gl[i], 8'h00);
            frame_check(9'h05a, 1'b1, 1'b0);
        end
        send(9'h03c, 1'b0, 1'b0, 8'h00, 8'h00);
        frame_check(9'h03c, 1'b0, 1'b1);
        send(9'h000, 1'b0, 1'b0, 8'h00, 8'h00);
        frame_check(9'h000, 1'b0, 1'b1);
        $display("test sampling done");
        send(9'h000, 1'b0, 1'b1, 8'h00, 8'h04);
        chk_bit("false start", 1'b0, rx_full_flag);
        send(9'h081, 1'b0, 1'b1, 8'h00, 8'h00);
        frame_check(9'h081, 1'b0, 1'b0);
        bus_wr(`REG_CONTROL, c_en | c_l9);
        send(9'h1a5, 1'b1, 1'b1, 8'h00, 8'h00);
        frame_check(9'h1a5, 1'b0, 1'b0);
        $display("test start and length done");
        bus_wr(`REG_CONTROL, c_en);
        bus_rd(`REG_DATA, rd);
        send(9'h0ff, 1'b0, 1'b1, 8'h00, 8'h00);
        wait_ticks(24);
        bus_rd(`REG_STATUS, rd);
        chk_bit("idle early", 1'b1, rd[`ST_IDLE]);
        frame_check(9'h0ff, 1'b0, 1'b0);
        bus_wr(`REG_CONTROL, c_en | c_st);
        send(9'h0ff, 1'b0, 1'b1, 8'h00, 8'h00);
        wait_ticks(24);
        bus_rd(`REG_STATUS, rd);
        chk_bit("idle late", 1'b0, rd[`ST_IDLE]);
        wait_ticks(160);
        bus_rd(`REG_STATUS, rd);
        chk_bit("idle after stop", 1'b1, rd[`ST_IDLE]);
        frame_check(9'h0ff, 1'b0, 1'b0);
        $display("test idle done");
        bus_wr(`REG_CONTROL, c_en | c_wk | c_sb);
        send(9'h012, 1'b0, 1'b1, 8'h00, 8'h00);
        chk_bit("standby drop", 1'b0, rx_full_flag);
        chk_bit("standby held", 1'b1, rx_standby_request);
        send(9'h092, 1'b0, 1'b1, 8'h00, 8'h00);
        chk_bit("mark wake", 1'b0, rx_standby_request);
        frame_check(9'h092, 1'b0, 1'b0);
        bus_wr(`REG_CONTROL, c_en | c_wk | c_sb);
        chk_bit("standby again", 1'b1, rx_standby_request);
        bus_wr(`REG_CONTROL, c_en | c_sb);
        wait_ticks(200);
        chk_bit("idle wake", 1'b0, rx_standby_request);
        chk_bit("idle wake full", 1'b0, rx_full_flag);
        bus_rd(`REG_STATUS, rd);
        chk_bit("idle wake flag", 1'b0, rd[`ST_IDLE]);
        $display("test wakeup done");
        test_done();
    end
endmodule : test_uart_rx_sampling_wakeup
